// ---- vdc_pkg.sv ----
package vdc_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] VDC_IDX_CR0    = 12'h440;
  localparam logic [11:0] VDC_IDX_CR1    = 12'h441;
  localparam logic [11:0] VDC_IDX_CR2    = 12'h442;
  localparam logic [11:0] VDC_IDX_TIME   = 12'h445;
  localparam logic [11:0] VDC_IDX_MODE   = 12'h446;
  localparam logic [11:0] VDC_IDX_GLOBAL = 12'h449;
  localparam logic [11:0] VDC_IDX_STAT   = 12'h44a;
  localparam logic [11:0] VDC_IDX_MASK   = 12'h44b;
  // control byte field positions
  localparam int VDC_BIT_START  = 7;
  localparam int VDC_BIT_BAND   = 6;
  localparam int VDC_BIT_PERMIT = 5;
  localparam int VDC_BIT_RESULT = 4;
  localparam int VDC_BIT_DRIVE  = 3;
  localparam int VDC_MODE_LSB   = 3;
  localparam logic [7:0] VDC_RST_BYTE = 8'h00;
  localparam logic [3:0] VDC_LEVEL0_MAX = 4'hb;
  localparam logic [2:0] VDC_LEVEL1_MAX = 3'h4;
  localparam logic [1:0] VDC_LEVEL2_MAX = 2'h2;
  // intermittent sampling periods minus one, in cycles
  localparam int VDC_CNT_W = 12;
  localparam logic [11:0] VDC_PERIOD0 = 12'h00f;
  localparam logic [11:0] VDC_PERIOD1 = 12'h03f;
  localparam logic [11:0] VDC_PERIOD2 = 12'h0ff;
  localparam logic [11:0] VDC_PERIOD3 = 12'h3ff;
  localparam logic [1:0] VDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VDC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {VDC_W_IDLE = 2'h0, VDC_W_ADDR = 2'h1, VDC_W_RESP = 2'h3, VDC_W_DATA = 2'h2} vdc_wstate_type;

  function automatic logic [11:0] vdc_period(input logic [1:0] t);
    case (t)
      2'h0: vdc_period = VDC_PERIOD0;
      2'h1: vdc_period = VDC_PERIOD1;
      2'h2: vdc_period = VDC_PERIOD2;
      default: vdc_period = VDC_PERIOD3;
    endcase
  endfunction

  function automatic logic vdc_hit(input logic [15:0] addr, input logic [11:0] idx);
    vdc_hit = (addr == {2'h0, idx, 2'h0});
  endfunction
endpackage

// ---- vdc_chan_if.sv ----
interface vdc_chan_if;
  logic       active;
  logic       sampleMode;
  logic [1:0] sampleTime;
  logic       decline;
  logic       clearReq;
  logic       strobe;
  logic       flag;
  modport ctrl(output active, output sampleMode, output sampleTime, output decline, output clearReq,
               input strobe, input flag);
  modport sampler(input active, input sampleMode, input sampleTime, input decline, input clearReq,
                  output strobe, output flag);
endinterface

// ---- vdc_sampler.sv ----
module vdc_sampler
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // channel
  vdc_chan_if.sampler ch
);
  logic [11:0] cntReg;
  logic [11:0] cntNext;
  logic        strobeReg;
  logic        flagReg;

  always_comb
  begin
    if (!ch.active || cntReg == 12'h000)
      cntNext = vdc_pkg::vdc_period(ch.sampleTime);
    else
      cntNext = cntReg - 12'h001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cntReg <= vdc_pkg::VDC_PERIOD0;
    else
      cntReg <= cntNext;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      strobeReg <= 1'b0;
    else
      strobeReg <= ch.active && (!ch.sampleMode || cntReg == 12'h000);
  end

  // a decline seen in the read-clear cycle survives the clear
  // strobe lags active by one cycle, so gate it: a switched-off comparator is not read
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flagReg <= 1'b0;
    else if (strobeReg && ch.active && ch.decline)
      flagReg <= 1'b1;
    else if (ch.clearReq)
      flagReg <= 1'b0;
  end

  assign ch.strobe = strobeReg;
  assign ch.flag   = flagReg;

  chk_continuous_sample: assert property (@(posedge ref_clk) disable iff (rst)
    (ch.active && !ch.sampleMode) |=> strobeReg) else $error("continuous sampling missed a cycle");
  chk_intermittent_gap: assert property (@(posedge ref_clk) disable iff (rst)
    (ch.active && ch.sampleMode && $past(ch.sampleMode) && strobeReg) |=> (!strobeReg || !ch.sampleMode) [*8])
    else $error("intermittent samples too close");
  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (strobeReg && ch.active && ch.decline) |=> flagReg) else $error("decline not latched");
  cov_intermittent: cover property (@(posedge ref_clk) disable iff (rst) ch.sampleMode && strobeReg && ch.decline);
endmodule

// ---- vdc_voltage_detect_control.sv ----
// Contract
// - channel 0 level accepts codes 00H to 0BH
// - channel 1 level accepts codes 00H to 04H
// - channel 2 level accepts codes 00H to 02H
// - drive select 0 main supply, 1 reference
// - per-channel use bit enables channel
// - mode bit: continuous or timed intermittent sampling
// - detection start and interrupt permit bits
// - result flag shows decline, cleared on read
// - detection interrupts wake processor from halt
//
// Local design decision: the AXI4-Lite interface to the registers.
module vdc_voltage_detect_control
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // axi4-lite slave
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog comparators
  input  wire logic [2:0]  compDecline,
  output logic [2:0]       compEnable,
  output logic [2:0]       compSample,
  output logic [3:0]       compLevelCh0,
  output logic [2:0]       compLevelCh1,
  output logic [1:0]       compLevelCh2,
  output logic             comparatorDriveSelect,
  output logic             levelBandFlag,
  // interrupts
  output logic [2:0]       lowVoltageIrq,
  output logic             haltWake,
  output logic             irq
);
  vdc_pkg::vdc_wstate_type wStateReg;
  vdc_pkg::vdc_wstate_type wStateNext;
  logic [15:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0]  wStrbReg;
  logic [15:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        doWrite;
  logic        wrLane;
  logic [1:0]  bRespReg;
  logic        rValidReg;
  logic [31:0] rDataReg;
  logic [1:0]  rRespReg;
  logic [7:0]  readByte;
  logic        readHit;
  logic        arHs;

  logic [2:0] detectStartReg;
  logic [2:0] irqPermitReg;
  logic       levelBandReg;
  logic [3:0] level0Reg;
  logic [2:0] level1Reg;
  logic [1:0] level2Reg;
  logic [5:0] sampleTimeReg;
  logic [2:0] sampleModeReg;
  logic [2:0] inUseReg;
  logic       driveSelReg;
  logic [2:0] lowVoltIrqReg;
  logic [2:0] lowVoltPrevReg;
  logic [2:0] flagVec;
  logic [2:0] strobeVec;
  logic [2:0] clearVec;
  logic [2:0] irqStatus;
  logic [2:0] irqMask;

  // ---------------- write channel ----------------
  assign s_axi_awready = (wStateReg == vdc_pkg::VDC_W_IDLE) || (wStateReg == vdc_pkg::VDC_W_DATA);
  assign s_axi_wready  = (wStateReg == vdc_pkg::VDC_W_IDLE) || (wStateReg == vdc_pkg::VDC_W_ADDR);
  assign s_axi_bvalid  = (wStateReg == vdc_pkg::VDC_W_RESP);
  assign s_axi_bresp   = bRespReg;

  always_comb
  begin
    wStateNext = wStateReg;
    case (wStateReg)
      vdc_pkg::VDC_W_IDLE:
      begin
        if (s_axi_awvalid && s_axi_wvalid)
          wStateNext = vdc_pkg::VDC_W_RESP;
        else if (s_axi_awvalid)
          wStateNext = vdc_pkg::VDC_W_ADDR;
        else if (s_axi_wvalid)
          wStateNext = vdc_pkg::VDC_W_DATA;
      end
      vdc_pkg::VDC_W_ADDR:
      begin
        if (s_axi_wvalid)
          wStateNext = vdc_pkg::VDC_W_RESP;
      end
      vdc_pkg::VDC_W_DATA:
      begin
        if (s_axi_awvalid)
          wStateNext = vdc_pkg::VDC_W_RESP;
      end
      default:
      begin
        if (s_axi_bready)
          wStateNext = vdc_pkg::VDC_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wStateReg <= vdc_pkg::VDC_W_IDLE;
    else
      wStateReg <= wStateNext;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      awAddrReg <= 16'h0000;
      wDataReg  <= 32'h0000_0000;
      wStrbReg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        awAddrReg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
    end
  end

  // the write lands in the cycle the second half of the pair is taken
  assign wrAddr  = s_axi_awready ? s_axi_awaddr : awAddrReg;
  assign wrData  = s_axi_wready ? s_axi_wdata : wDataReg;
  assign wrStrb  = s_axi_wready ? s_axi_wstrb : wStrbReg;
  assign doWrite = (wStateNext == vdc_pkg::VDC_W_RESP) && (wStateReg != vdc_pkg::VDC_W_RESP);
  assign wrLane  = doWrite && wrStrb[0];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      bRespReg <= vdc_pkg::VDC_RESP_OKAY;
    else if (doWrite)
    begin
      if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR0) || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR1)
          || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR2) || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_TIME)
          || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_MODE) || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_GLOBAL)
          || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_STAT) || vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_MASK))
        bRespReg <= vdc_pkg::VDC_RESP_OKAY;
      else
        bRespReg <= vdc_pkg::VDC_RESP_SLVERR;
    end
  end

  // ---------------- channel control registers ----------------
  // out-of-range level codes are dropped so the threshold never points at nothing
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      detectStartReg <= 3'h0;
      irqPermitReg   <= 3'h0;
      levelBandReg   <= 1'b0;
      level0Reg      <= 4'h0;
      level1Reg      <= 3'h0;
      level2Reg      <= 2'h0;
    end
    else if (wrLane)
    begin
      if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR0))
      begin
        detectStartReg[0] <= wrData[vdc_pkg::VDC_BIT_START];
        irqPermitReg[0]   <= wrData[vdc_pkg::VDC_BIT_PERMIT];
        levelBandReg      <= wrData[vdc_pkg::VDC_BIT_BAND];
        if (wrData[3:0] <= vdc_pkg::VDC_LEVEL0_MAX)
          level0Reg <= wrData[3:0];
      end
      else if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR1))
      begin
        detectStartReg[1] <= wrData[vdc_pkg::VDC_BIT_START];
        irqPermitReg[1]   <= wrData[vdc_pkg::VDC_BIT_PERMIT];
        if (wrData[3:0] <= {1'b0, vdc_pkg::VDC_LEVEL1_MAX})
          level1Reg <= wrData[2:0];
      end
      else if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_CR2))
      begin
        detectStartReg[2] <= wrData[vdc_pkg::VDC_BIT_START];
        irqPermitReg[2]   <= wrData[vdc_pkg::VDC_BIT_PERMIT];
        if (wrData[3:0] <= {2'h0, vdc_pkg::VDC_LEVEL2_MAX})
          level2Reg <= wrData[1:0];
      end
    end
  end

  // ---------------- global, timing and mode registers ----------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sampleTimeReg <= vdc_pkg::VDC_RST_BYTE[5:0];
      sampleModeReg <= vdc_pkg::VDC_RST_BYTE[2:0];
      inUseReg      <= vdc_pkg::VDC_RST_BYTE[2:0];
      driveSelReg   <= 1'b0;
    end
    else if (wrLane)
    begin
      if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_TIME))
        sampleTimeReg <= wrData[5:0];
      else if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_MODE))
        sampleModeReg <= wrData[vdc_pkg::VDC_MODE_LSB +: 3];
      else if (vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_GLOBAL))
      begin
        inUseReg    <= wrData[2:0];
        driveSelReg <= wrData[vdc_pkg::VDC_BIT_DRIVE];
      end
    end
  end

  // ---------------- read channel ----------------
  assign arHs          = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rValidReg;
  assign s_axi_rvalid  = rValidReg;
  assign s_axi_rdata   = rDataReg;
  assign s_axi_rresp   = rRespReg;

  always_comb
  begin
    readHit  = 1'b1;
    readByte = 8'h00;
    if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR0))
      readByte = {detectStartReg[0], levelBandReg, irqPermitReg[0], flagVec[0], level0Reg};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR1))
      readByte = {detectStartReg[1], 1'b0, irqPermitReg[1], flagVec[1], 1'b0, level1Reg};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR2))
      readByte = {detectStartReg[2], 1'b0, irqPermitReg[2], flagVec[2], 2'h0, level2Reg};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_TIME))
      readByte = {2'h0, sampleTimeReg};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_MODE))
      readByte = {2'h0, sampleModeReg, 3'h0};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_GLOBAL))
      readByte = {4'h0, driveSelReg, inUseReg};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_STAT))
      readByte = {5'h00, irqStatus};
    else if (vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_MASK))
      readByte = {5'h00, irqMask};
    else
      readHit = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rValidReg <= 1'b0;
      rDataReg  <= 32'h0000_0000;
      rRespReg  <= vdc_pkg::VDC_RESP_OKAY;
    end
    else if (arHs)
    begin
      rValidReg <= 1'b1;
      rDataReg  <= {24'h000000, readByte};
      rRespReg  <= readHit ? vdc_pkg::VDC_RESP_OKAY : vdc_pkg::VDC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rValidReg <= 1'b0;
  end

  // flag is cleared when the read is taken, so the returned byte still shows it
  assign clearVec[0] = arHs && vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR0);
  assign clearVec[1] = arHs && vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR1);
  assign clearVec[2] = arHs && vdc_pkg::vdc_hit(s_axi_araddr, vdc_pkg::VDC_IDX_CR2);

  // ---------------- per-channel samplers ----------------
  for (genvar i = 0; i < 3; i++)
  begin : g_ch
    vdc_chan_if chIf ();
    assign chIf.active     = inUseReg[i] && detectStartReg[i];
    assign chIf.sampleMode = sampleModeReg[i];
    assign chIf.sampleTime = sampleTimeReg[2*i +: 2];
    assign chIf.decline    = compDecline[i];
    assign chIf.clearReq   = clearVec[i];
    assign flagVec[i]      = chIf.flag;
    assign strobeVec[i]    = chIf.strobe;
    vdc_sampler u_sampler
    (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ch      (chIf.sampler)
    );
  end

  // ---------------- interrupts ----------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lowVoltIrqReg  <= 3'h0;
      lowVoltPrevReg <= 3'h0;
    end
    else
    begin
      lowVoltIrqReg  <= inUseReg & detectStartReg & flagVec & irqPermitReg;
      lowVoltPrevReg <= lowVoltIrqReg;
    end
  end

  vdc_irq #(.N(3)) u_irq
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .evt      (lowVoltIrqReg & ~lowVoltPrevReg),
    .clrWe    (wrLane && vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_STAT)),
    .clrBits  (wrData[2:0]),
    .maskWe   (wrLane && vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_MASK)),
    .maskBits (wrData[2:0]),
    .status   (irqStatus),
    .mask     (irqMask),
    .irq      (irq)
  );

  assign lowVoltageIrq         = lowVoltIrqReg;
  assign haltWake              = |lowVoltIrqReg;
  assign compEnable            = inUseReg & detectStartReg;
  assign compSample            = strobeVec;
  assign compLevelCh0          = level0Reg;
  assign compLevelCh1          = level1Reg;
  assign compLevelCh2          = level2Reg;
  assign comparatorDriveSelect = driveSelReg;
  assign levelBandFlag         = levelBandReg;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_level0_range: assert property (level0Reg <= vdc_pkg::VDC_LEVEL0_MAX)
    else $error("channel 0 level out of range");
  chk_level1_range: assert property (level1Reg <= vdc_pkg::VDC_LEVEL1_MAX)
    else $error("channel 1 level out of range");
  chk_level2_range: assert property (level2Reg <= vdc_pkg::VDC_LEVEL2_MAX)
    else $error("channel 2 level out of range");
  chk_drive_write: assert property (
    (wrLane && vdc_pkg::vdc_hit(wrAddr, vdc_pkg::VDC_IDX_GLOBAL))
      |=> comparatorDriveSelect == $past(wrData[vdc_pkg::VDC_BIT_DRIVE]))
    else $error("drive select not updated");
  chk_enable_gate: assert property (compSample[0] |-> $past(inUseReg[0] && detectStartReg[0]))
    else $error("sample while channel off");
  chk_result_clear: assert property (
    (clearVec[0] && !(strobeVec[0] && compDecline[0])) |=> !flagVec[0])
    else $error("result flag not cleared by read");
  chk_irq_cause: assert property (
    lowVoltageIrq[0] |-> $past(inUseReg[0] && detectStartReg[0] && flagVec[0] && irqPermitReg[0]))
    else $error("interrupt without cause");
  chk_permit_block: assert property (
    (!irqPermitReg[0] ##1 !irqPermitReg[0]) |-> !lowVoltageIrq[0])
    else $error("interrupt while not permitted");
  chk_halt_wake: assert property ($rose(|lowVoltageIrq) |-> haltWake ##1 haltWake || !(|lowVoltageIrq))
    else $error("halt wake missing");
  chk_write_resp: assert property (doWrite |=> s_axi_bvalid)
    else $error("write response not raised");

  cov_decline_irq: cover property ($rose(lowVoltageIrq[0]) ##[1:4] irq);
  cov_read_clear: cover property (clearVec[1] && flagVec[1]);
  cov_both_same: cover property (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready);
endmodule

// ---- vdc_irq.sv ----
module vdc_irq #(parameter int N = 3)
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // events and software access
  input  wire logic [N-1:0] evt,
  input  wire logic         clrWe,
  input  wire logic [N-1:0] clrBits,
  input  wire logic         maskWe,
  input  wire logic [N-1:0] maskBits,
  // state
  output logic [N-1:0]      status,
  output logic [N-1:0]      mask,
  output logic              irq
);
  logic [N-1:0] statusReg;
  logic [N-1:0] maskReg;

  // set wins over a one-to-clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      statusReg <= '0;
    else
      statusReg <= (statusReg & ~(clrWe ? clrBits : '0)) | evt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      maskReg <= '0;
    else if (maskWe)
      maskReg <= maskBits;
  end

  assign status = statusReg;
  assign mask   = maskReg;
  assign irq    = |(statusReg & maskReg);

  chk_irq_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (evt[0] && maskReg[0] && !maskWe) |=> irq) else $error("masked-in event gave no interrupt");
endmodule

// ---- vdc_comp_model.sv ----
module vdc_comp_model
(
  // clock and test controls
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [2:0] want,
  // comparator side
  input  wire logic [2:0] compEnable,
  output logic      [2:0] compDecline
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wantLag_reg = 3'h0;
  logic [2:0] last_reg = 3'h0;

  // slow comparator answers one cycle late
  always @(posedge ref_clk)
  begin
    wantLag_reg <= want;
    last_reg <= (compEnable & compDecline) | (~compEnable & last_reg);
  end

  // a disabled comparator parks at the inverse of its last enabled level
  assign compDecline = ((slow ? wantLag_reg : want) & compEnable) | (~last_reg & ~compEnable);
endmodule

// ---- test_vdc_voltage_detect_control.sv ----
module test_vdc_voltage_detect_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        slow = 1'b0;
  logic [2:0]  want = 3'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0]  compDecline, compEnable, compSample, lowVoltageIrq, compLevelCh1;
  logic [3:0]  compLevelCh0;
  logic [1:0]  compLevelCh2;
  logic        comparatorDriveSelect, levelBandFlag, haltWake, irq;
  int          nErrors = 0;
  int          checkCount = 0;

  always #5 ref_clk = ~ref_clk;

  vdc_voltage_detect_control i_dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .compDecline, .compEnable, .compSample, .compLevelCh0,
    .compLevelCh1, .compLevelCh2, .comparatorDriveSelect, .levelBandFlag, .lowVoltageIrq,
    .haltWake, .irq);

  vdc_comp_model i_comp (.ref_clk, .slow, .want, .compEnable, .compDecline);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] expResp);
    int t;
    t = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      t++;
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, t < 50 ? expResp : 2'h1);
  endtask

  task automatic axiRead(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge ref_clk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      t++;
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    d = t < 50 ? s_axi_rdata : 32'hdeadbeef;
    r = s_axi_rresp;
  endtask

  task automatic rdChk(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(idx, d, r);
    check(d, {24'h000000, exp});
    check(r, vdc_pkg::VDC_RESP_OKAY);
  endtask

  task automatic testReset;
    logic [11:0] idx [8];
    logic [31:0] d;
    logic [1:0]  r;
    idx = '{vdc_pkg::VDC_IDX_CR0, vdc_pkg::VDC_IDX_CR1, vdc_pkg::VDC_IDX_CR2, vdc_pkg::VDC_IDX_TIME,
            vdc_pkg::VDC_IDX_MODE, vdc_pkg::VDC_IDX_GLOBAL, vdc_pkg::VDC_IDX_STAT, vdc_pkg::VDC_IDX_MASK};
    for (int i = 0; i < 8; i++)
      rdChk(idx[i], vdc_pkg::VDC_RST_BYTE);
    check({compEnable, lowVoltageIrq, haltWake, irq}, 8'h00);
    axiRead(12'h443, d, r);
    check(d, 32'h00000000);
    check(r, vdc_pkg::VDC_RESP_SLVERR);
    axiWrite(12'h443, 8'hff, vdc_pkg::VDC_RESP_SLVERR);
    $display("test reset done");
  endtask

  // legal top code kept, first illegal code leaves the level alone
  task automatic testLevels;
    logic [11:0] idx [3];
    logic [7:0]  good [3];
    logic [7:0]  bad [3];
    idx = '{vdc_pkg::VDC_IDX_CR0, vdc_pkg::VDC_IDX_CR1, vdc_pkg::VDC_IDX_CR2};
    good = '{8'h4b, 8'h04, 8'h02};
    bad = '{8'h0c, 8'h05, 8'h03};
    for (int i = 0; i < 3; i++)
    begin
      axiWrite(idx[i], good[i], vdc_pkg::VDC_RESP_OKAY);
      rdChk(idx[i], good[i]);
      axiWrite(idx[i], bad[i], vdc_pkg::VDC_RESP_OKAY);
      rdChk(idx[i], good[i] & 8'h0f);
    end
    check({compLevelCh0, compLevelCh1, compLevelCh2, levelBandFlag}, {4'hb, 3'h4, 2'h2, 1'b0});
    $display("test levels done");
  endtask

  task automatic testGlobal;
    axiWrite(vdc_pkg::VDC_IDX_GLOBAL, 8'h0d, vdc_pkg::VDC_RESP_OKAY);
    rdChk(vdc_pkg::VDC_IDX_GLOBAL, 8'h0d);
    check(comparatorDriveSelect, 1'b1);
    axiWrite(vdc_pkg::VDC_IDX_CR0, 8'h80, vdc_pkg::VDC_RESP_OKAY);
    axiWrite(vdc_pkg::VDC_IDX_CR1, 8'h80, vdc_pkg::VDC_RESP_OKAY);
    axiWrite(vdc_pkg::VDC_IDX_CR2, 8'h80, vdc_pkg::VDC_RESP_OKAY);
    check(compEnable, 3'b101);
    axiWrite(vdc_pkg::VDC_IDX_GLOBAL, 8'h00, vdc_pkg::VDC_RESP_OKAY);
    check({compEnable, comparatorDriveSelect}, 4'h0);
    $display("test global done");
  endtask

  task automatic testDetect;
    int t;
    slow <= 1'b1;
    axiWrite(vdc_pkg::VDC_IDX_GLOBAL, 8'h01, vdc_pkg::VDC_RESP_OKAY);
    axiWrite(vdc_pkg::VDC_IDX_CR0, 8'h80, vdc_pkg::VDC_RESP_OKAY);
    want <= 3'b001;
    repeat (10) @(posedge ref_clk);
    check(lowVoltageIrq, 3'h0);
    rdChk(vdc_pkg::VDC_IDX_CR0, 8'h90);
    axiWrite(vdc_pkg::VDC_IDX_CR0, 8'ha0, vdc_pkg::VDC_RESP_OKAY);
    t = 0;
    while (lowVoltageIrq[0] !== 1'b1 && t < 20)
    begin
      @(posedge ref_clk);
      t++;
    end
    check({lowVoltageIrq, haltWake}, 4'b0011);
    repeat (3) @(posedge ref_clk);
    check(irq, 1'b0);
    axiWrite(vdc_pkg::VDC_IDX_MASK, 8'h01, vdc_pkg::VDC_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b1);
    want <= 3'b000;
    repeat (5) @(posedge ref_clk);
    rdChk(vdc_pkg::VDC_IDX_CR0, 8'hb0);
    rdChk(vdc_pkg::VDC_IDX_CR0, 8'ha0);
    repeat (3) @(posedge ref_clk);
    check({lowVoltageIrq, haltWake, irq}, 5'b00001);
    rdChk(vdc_pkg::VDC_IDX_STAT, 8'h01);
    axiWrite(vdc_pkg::VDC_IDX_STAT, 8'h01, vdc_pkg::VDC_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    check(irq, 1'b0);
    axiWrite(vdc_pkg::VDC_IDX_CR0, 8'h00, vdc_pkg::VDC_RESP_OKAY);
    slow <= 1'b0;
    $display("test detect done");
  endtask

  // any window of four periods holds exactly four strobes
  task automatic testSample;
    int n;
    axiWrite(vdc_pkg::VDC_IDX_GLOBAL, 8'h02, vdc_pkg::VDC_RESP_OKAY);
    axiWrite(vdc_pkg::VDC_IDX_MODE, 8'h10, vdc_pkg::VDC_RESP_OKAY);
    axiWrite(vdc_pkg::VDC_IDX_CR1, 8'h80, vdc_pkg::VDC_RESP_OKAY);
    for (int tm = 0; tm < 2; tm++)
    begin
      axiWrite(vdc_pkg::VDC_IDX_TIME, 8'(tm << 2), vdc_pkg::VDC_RESP_OKAY);
      repeat (128) @(posedge ref_clk);
      n = 0;
      repeat (tm == 0 ? 64 : 256)
      begin
        @(posedge ref_clk);
        n += (compSample[1] === 1'b1) ? 1 : 0;
      end
      check(32'(n), 32'h4);
    end
    axiWrite(vdc_pkg::VDC_IDX_MODE, 8'h00, vdc_pkg::VDC_RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    check(compSample, 3'b010);
    $display("test sample done");
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    testReset();
    testLevels();
    testGlobal();
    testDetect();
    testSample();
    closeOut();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    nErrors++;
    closeOut();
  end
endmodule
